//--- bmd_pkg.sv
/*
 * Package for the byte move decoder: opcode patterns, field positions,
 * byte counts, cycle counts and the decode and memory request carriers.
 * Assumes a single core clock domain; nothing here holds state.
 */
package bmd_pkg;

    // ------------------------------------------------------------
    // Opcode patterns (upper bits compared under a mask; E5 and 74 compared whole)
    // ------------------------------------------------------------
    localparam logic [7:0] BMD_OP_A_DIR      = 8'hE5;  // Accumulator from direct
    localparam logic [7:0] BMD_OP_A_REG      = 8'hE8;  // Accumulator from bank register
    localparam logic [7:0] BMD_OP_A_IND      = 8'hE6;  // Accumulator from indirect
    localparam logic [7:0] BMD_OP_A_IMM      = 8'h74;  // Accumulator from constant
    localparam logic [7:0] BMD_OP_REG_A      = 8'hF8;  // Bank register from accumulator
    localparam logic [7:0] BMD_OP_REG_DIR    = 8'hA8;  // Bank register from direct
    localparam logic [7:0] BMD_OP_REG_IMM    = 8'h78;  // Bank register from constant
    localparam logic [7:0] BMD_OP_IND_A      = 8'hF6;  // Indirect from accumulator
    localparam logic [7:0] BMD_OP_IND_DIR    = 8'hA6;  // Indirect from direct
    localparam logic [7:0] BMD_OP_IND_IMM    = 8'h76;  // Indirect from constant
    localparam logic [7:0] BMD_MASK_REG      = 8'hF8;  // Keeps opcode, drops rrr
    localparam logic [7:0] BMD_MASK_IND      = 8'hFE;  // Keeps opcode, drops i

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int BMD_REG_LSB   = 0;                  // rrr field low bit
    localparam int BMD_REG_W     = 3;                  // rrr field width
    localparam int BMD_PTR_BIT   = 0;                  // i bit

    // ------------------------------------------------------------
    // Timing and size: machine cycles and bytes per instruction
    // ------------------------------------------------------------
    localparam logic [1:0] BMD_CYC_ONE   = 2'h1;       // One machine cycle
    localparam logic [1:0] BMD_CYC_TWO   = 2'h2;       // Two machine cycles
    localparam logic [1:0] BMD_LEN_ONE   = 2'h1;       // One byte long
    localparam logic [1:0] BMD_LEN_TWO   = 2'h2;       // Two bytes long

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] BMD_ACC_RST   = 8'h00;      // Accumulator after reset
    localparam logic [1:0] BMD_BANK_RST  = 2'h0;       // Bank select after reset

    // Source and destination kinds
    typedef enum logic [1:0] {
        BMD_LOC_ACC = 2'h0,
        BMD_LOC_REG = 2'h1,
        BMD_LOC_IND = 2'h2,
        BMD_LOC_DIR = 2'h3
    } bmd_loc_t;

    // Decoded instruction
    typedef struct packed {
        logic       valid;     // Opcode belongs to this group
        bmd_loc_t   src;       // Where the byte comes from
        logic       src_imm;   // Source is the operand byte itself
        bmd_loc_t   dst;       // Where the byte goes
        logic [2:0] reg_sel;   // Bank register or pointer number
        logic [1:0] len;       // Instruction bytes
        logic [1:0] cycles;    // Machine cycles
    } bmd_dec_t;

    // Data memory request: reads and writes of internal RAM or SFR space
    typedef struct packed {
        logic       rd;        // Read strobe
        logic       wr;        // Write strobe
        logic [7:0] addr;      // Byte address
        logic [7:0] wdata;     // Write data
    } bmd_mem_req_t;

endpackage : bmd_pkg

//--- bmd_byte_move_decoder.sv
/*
 * Byte move decoder and executor. Holds the accumulator and four banks
 * of eight registers; direct and indirect bytes live in an outside data
 * memory reached through a read port answered in the strobe cycle and a write strobe.
 * Assumes program memory presents the opcode and operand byte together
 * with instr_valid_i, and holds them until instr_done_o.
 */
//
// Overview of operation
// - E5 plus direct: accumulator load, one cycle
// - 10101rrr direct to bank register, two cycles
// - 01111rrr immediate to bank register, one cycle
// - 1010011i direct to indirect RAM, two cycles
// - 0111011i immediate to indirect RAM, one cycle
// - Source unchanged; only destination is written
// - Indirect address from pointer register R0/R1
`timescale 1ns/1ps

module bmd_byte_move_decoder (
    // Clock and reset
    input  wire logic                 clk_i,
    input  wire logic                 reset_i,
    // Instruction bytes from program memory
    input  wire logic                 instr_valid_i,
    input  wire logic [7:0]           opcode_i,
    input  wire logic [7:0]           operand_i,
    // Active register bank from the status word
    input  wire logic [1:0]           bank_sel_i,
    // Data memory port
    output      bmd_pkg::bmd_mem_req_t mem_req_o,
    input  wire logic [7:0]           mem_rdata_i,
    // Status toward the core
    output      logic                 instr_done_o,
    output      logic                 instr_illegal_o,
    output      logic [1:0]           instr_len_o,
    output      logic [7:0]           acc_o
);

    // ------------------------------------------------------------
    // State and storage
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        BMD_ST_IDLE = 2'b00,   // Waiting for an instruction
        BMD_ST_READ = 2'b01,   // Source read issued
        BMD_ST_DONE = 2'b11    // Answer cycle
    } bmd_state_t;

    bmd_state_t             state_r, state_nxt;     // Sequencer
    bmd_pkg::bmd_dec_t      dec;                    // Decode of opcode_i
    bmd_pkg::bmd_dec_t      dec_r, dec_nxt;         // Held decode
    logic [7:0]             acc_r, acc_nxt;         // Accumulator
    logic [7:0]             bank_r [0:31];          // Four banks of eight
    logic [7:0]             src_r, src_nxt;         // Captured source byte
    logic [7:0]             opnd_r, opnd_nxt;       // Held operand byte
    logic [1:0]             cnt_r, cnt_nxt;         // Machine cycle counter
    logic                   done_r, done_nxt;       // Completion pulse
    logic                   ill_r, ill_nxt;         // Illegal opcode pulse
    logic [1:0]             len_r, len_nxt;         // Length of last instruction
    logic                   breg_we;                // Bank register write
    logic [4:0]             breg_idx;               // Bank register index
    logic [7:0]             breg_wd;                // Bank register data
    logic [4:0]             rd_idx;                 // Register read index
    logic [7:0]             ptr_val;                // Pointer register value
    bmd_pkg::bmd_mem_req_t  req_nxt, req_r;         // Memory request

    // ------------------------------------------------------------
    // Opcode decode
    // ------------------------------------------------------------
    // Classifies the opcode into source, destination, size and timing
    always_comb begin
        dec         = '0;
        dec.reg_sel = opcode_i[bmd_pkg::BMD_REG_LSB +: bmd_pkg::BMD_REG_W];
        dec.len     = bmd_pkg::BMD_LEN_TWO;
        dec.cycles  = bmd_pkg::BMD_CYC_ONE;
        if (opcode_i == bmd_pkg::BMD_OP_A_DIR) begin
            dec.valid = 1'b1;
            dec.src   = bmd_pkg::BMD_LOC_DIR;
            dec.dst   = bmd_pkg::BMD_LOC_ACC;
        end else if ((opcode_i & bmd_pkg::BMD_MASK_REG) == bmd_pkg::BMD_OP_A_REG) begin
            dec.valid = 1'b1;
            dec.src   = bmd_pkg::BMD_LOC_REG;
            dec.dst   = bmd_pkg::BMD_LOC_ACC;
            dec.len   = bmd_pkg::BMD_LEN_ONE;
        end else if ((opcode_i & bmd_pkg::BMD_MASK_IND) == bmd_pkg::BMD_OP_A_IND) begin
            dec.valid = 1'b1;
            dec.src   = bmd_pkg::BMD_LOC_IND;
            dec.dst   = bmd_pkg::BMD_LOC_ACC;
            dec.len   = bmd_pkg::BMD_LEN_ONE;
        end else if (opcode_i == bmd_pkg::BMD_OP_A_IMM) begin
            dec.valid   = 1'b1;
            dec.src_imm = 1'b1;
            dec.dst     = bmd_pkg::BMD_LOC_ACC;
        end else if ((opcode_i & bmd_pkg::BMD_MASK_REG) == bmd_pkg::BMD_OP_REG_A) begin
            dec.valid = 1'b1;
            dec.src   = bmd_pkg::BMD_LOC_ACC;
            dec.dst   = bmd_pkg::BMD_LOC_REG;
            dec.len   = bmd_pkg::BMD_LEN_ONE;
        end else if ((opcode_i & bmd_pkg::BMD_MASK_REG) == bmd_pkg::BMD_OP_REG_DIR) begin
            dec.valid  = 1'b1;
            dec.src    = bmd_pkg::BMD_LOC_DIR;
            dec.dst    = bmd_pkg::BMD_LOC_REG;
            dec.cycles = bmd_pkg::BMD_CYC_TWO;
        end else if ((opcode_i & bmd_pkg::BMD_MASK_REG) == bmd_pkg::BMD_OP_REG_IMM) begin
            dec.valid   = 1'b1;
            dec.src_imm = 1'b1;
            dec.dst     = bmd_pkg::BMD_LOC_REG;
        end else if ((opcode_i & bmd_pkg::BMD_MASK_IND) == bmd_pkg::BMD_OP_IND_A) begin
            dec.valid = 1'b1;
            dec.src   = bmd_pkg::BMD_LOC_ACC;
            dec.dst   = bmd_pkg::BMD_LOC_IND;
            dec.len   = bmd_pkg::BMD_LEN_ONE;
        end else if ((opcode_i & bmd_pkg::BMD_MASK_IND) == bmd_pkg::BMD_OP_IND_DIR) begin
            dec.valid  = 1'b1;
            dec.src    = bmd_pkg::BMD_LOC_DIR;
            dec.dst    = bmd_pkg::BMD_LOC_IND;
            dec.cycles = bmd_pkg::BMD_CYC_TWO;
        end else if ((opcode_i & bmd_pkg::BMD_MASK_IND) == bmd_pkg::BMD_OP_IND_IMM) begin
            dec.valid   = 1'b1;
            dec.src_imm = 1'b1;
            dec.dst     = bmd_pkg::BMD_LOC_IND;
        end else begin
            dec.len = bmd_pkg::BMD_LEN_ONE;                                  // Not in this group
        end
    end

    // ------------------------------------------------------------
    // Register file read
    // ------------------------------------------------------------
    // Pointer uses only R0 or R1 of the active bank
    always_comb begin
        if (state_r == BMD_ST_IDLE) begin
            if (dec.src == bmd_pkg::BMD_LOC_IND || dec.dst == bmd_pkg::BMD_LOC_IND) begin
                rd_idx = {bank_sel_i, 2'b00, opcode_i[bmd_pkg::BMD_PTR_BIT]};
            end else begin
                rd_idx = {bank_sel_i, dec.reg_sel};
            end
        end else begin
            rd_idx = {bank_sel_i, 2'b00, dec_r.reg_sel[bmd_pkg::BMD_PTR_BIT]};
        end
        ptr_val = bank_r[rd_idx];
    end

    // ------------------------------------------------------------
    // Sequencer and data path
    // ------------------------------------------------------------
    // Computes next state, register writes and memory strobes
    always_comb begin
        state_nxt = state_r;
        dec_nxt   = dec_r;
        acc_nxt   = acc_r;
        src_nxt   = src_r;
        opnd_nxt  = opnd_r;
        cnt_nxt   = cnt_r;
        done_nxt  = 1'b0;
        ill_nxt   = 1'b0;
        len_nxt   = len_r;
        req_nxt   = '0;
        breg_we   = 1'b0;
        breg_idx  = {bank_sel_i, dec_r.reg_sel};
        breg_wd   = src_r;
        case (state_r)
            BMD_ST_IDLE: begin
                if (instr_valid_i && !done_r) begin
                    dec_nxt  = dec;
                    opnd_nxt = operand_i;
                    cnt_nxt  = dec.cycles;
                    len_nxt  = dec.len;
                    if (!dec.valid) begin
                        ill_nxt   = 1'b1;                                    // Outside group
                        done_nxt  = 1'b1;
                        state_nxt = BMD_ST_DONE;
                    end else begin
                        // Reads touch nothing; source stays intact
                        if (dec.src == bmd_pkg::BMD_LOC_DIR) begin
                            req_nxt.rd   = 1'b1;
                            req_nxt.addr = operand_i;
                        end else if (dec.src == bmd_pkg::BMD_LOC_IND) begin
                            req_nxt.rd   = 1'b1;
                            req_nxt.addr = ptr_val;
                        end
                        state_nxt = BMD_ST_READ;
                    end
                end
            end
            BMD_ST_READ: begin
                // Select the source byte
                if (dec_r.src_imm) begin
                    src_nxt = opnd_r;
                end else if (dec_r.src == bmd_pkg::BMD_LOC_ACC) begin
                    src_nxt = acc_r;
                end else if (dec_r.src == bmd_pkg::BMD_LOC_REG) begin
                    src_nxt = bank_r[{bank_sel_i, dec_r.reg_sel}];
                end else begin
                    src_nxt = mem_rdata_i;
                end
                breg_wd = src_nxt;
                cnt_nxt = cnt_r - 2'h1;
                if (cnt_r == bmd_pkg::BMD_CYC_ONE) begin
                    // Write only the destination
                    case (dec_r.dst)
                        bmd_pkg::BMD_LOC_ACC: acc_nxt = src_nxt;
                        bmd_pkg::BMD_LOC_REG: breg_we = 1'b1;
                        bmd_pkg::BMD_LOC_IND: begin
                            req_nxt.wr    = 1'b1;
                            req_nxt.addr  = ptr_val;
                            req_nxt.wdata = src_nxt;
                        end
                        default: ;
                    endcase
                    done_nxt  = 1'b1;
                    state_nxt = BMD_ST_DONE;
                end else begin
                    src_nxt = src_r;                                         // Second cycle follows
                    if (dec_r.src == bmd_pkg::BMD_LOC_DIR) begin
                        req_nxt.rd   = 1'b1;                                 // Keep read data stable
                        req_nxt.addr = opnd_r;
                    end
                end
            end
            BMD_ST_DONE: begin
                state_nxt = BMD_ST_IDLE;
            end
            default: begin
                state_nxt = BMD_ST_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // State registers
    // ------------------------------------------------------------
    // Registers all next values; control state reset synchronously
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            state_r <= BMD_ST_IDLE;
            dec_r   <= '0;
            acc_r   <= bmd_pkg::BMD_ACC_RST;
            src_r   <= '0;
            opnd_r  <= '0;
            cnt_r   <= '0;
            done_r  <= 1'b0;
            ill_r   <= 1'b0;
            len_r   <= '0;
            req_r   <= '0;
        end else begin
            state_r <= state_nxt;
            dec_r   <= dec_nxt;
            acc_r   <= acc_nxt;
            src_r   <= src_nxt;
            opnd_r  <= opnd_nxt;
            cnt_r   <= cnt_nxt;
            done_r  <= done_nxt;
            ill_r   <= ill_nxt;
            len_r   <= len_nxt;
            req_r   <= req_nxt;
        end
    end

    // Bank register storage; contents are not reset
    always_ff @(posedge clk_i) begin
        if (breg_we) begin
            bank_r[breg_idx] <= breg_wd;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign mem_req_o       = req_r;
    assign instr_done_o    = done_r;
    assign instr_illegal_o = ill_r;
    assign instr_len_o     = len_r;
    assign acc_o           = acc_r;

endmodule : bmd_byte_move_decoder

//--- bmd_move_chk.sv
/*
 * Checker for the byte move decoder: port-level timing and data relations.
 * Assumes it is bound to the decoder top and sees only its ports.
 */
`timescale 1ns/1ps

module bmd_move_chk (
    // Clock and reset
    input  wire logic                  clk_i,
    input  wire logic                  reset_i,
    // Instruction side
    input  wire logic                  instr_valid_i,
    input  wire logic [7:0]            opcode_i,
    input  wire logic [7:0]            operand_i,
    input  wire logic [1:0]            bank_sel_i,
    // Data memory side
    input  wire bmd_pkg::bmd_mem_req_t mem_req_o,
    input  wire logic [7:0]            mem_rdata_i,
    // Status
    input  wire logic                  instr_done_o,
    input  wire logic                  instr_illegal_o,
    input  wire logic [1:0]            instr_len_o,
    input  wire logic [7:0]            acc_o
);
    // ------------------------------------------------------------
    // Helper: tracks when a request is taken
    // ------------------------------------------------------------
    logic busy_r;                      // Instruction in flight
    logic busy_nxt;                    // Next busy value
    logic take;                        // Request taken at this edge

    assign take = instr_valid_i && !busy_r && !instr_done_o;

    // Busy from take until the done pulse
    always_comb begin
        busy_nxt = busy_r;
        if (take) begin
            busy_nxt = 1'b1;
        end else if (instr_done_o) begin
            busy_nxt = 1'b0;
        end
    end

    // Busy register, cleared by reset
    always_ff @(posedge clk_i) begin
        busy_r <= reset_i ? 1'b0 : busy_nxt;
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);

    // ------------------------------------------------------------
    // Sequences and properties
    // ------------------------------------------------------------
    sequence s_take(logic [7:0] m, logic [7:0] p);
        take && ((opcode_i & m) == p);
    endsequence
    sequence s_read;
        mem_req_o.rd && (mem_req_o.addr == $past(operand_i));
    endsequence

    property p_dir_acc;
        s_take(8'hFF, bmd_pkg::BMD_OP_A_DIR) |-> ##1 s_read ##1
            (instr_done_o && acc_o == $past(mem_rdata_i) && instr_len_o == 2'h2);
    endproperty
    a_dir_acc: assert property (p_dir_acc) else $error("direct load of acc wrong");

    property p_reg_dir;
        s_take(bmd_pkg::BMD_MASK_REG, bmd_pkg::BMD_OP_REG_DIR) |-> ##1 s_read ##2
            (instr_done_o && instr_len_o == 2'h2);
    endproperty
    a_reg_dir: assert property (p_reg_dir) else $error("direct to register wrong");

    property p_reg_imm;
        s_take(bmd_pkg::BMD_MASK_REG, bmd_pkg::BMD_OP_REG_IMM) |->
            ##1 (!mem_req_o.rd && !mem_req_o.wr) ##1 (instr_done_o && !mem_req_o.wr);
    endproperty
    a_reg_imm: assert property (p_reg_imm) else $error("constant to register wrong");

    property p_ind_dir;
        s_take(bmd_pkg::BMD_MASK_IND, bmd_pkg::BMD_OP_IND_DIR) |-> ##1 s_read ##2
            (instr_done_o && mem_req_o.wr && mem_req_o.wdata == $past(mem_rdata_i));
    endproperty
    a_ind_dir: assert property (p_ind_dir) else $error("direct to indirect wrong");

    property p_ind_imm;
        s_take(bmd_pkg::BMD_MASK_IND, bmd_pkg::BMD_OP_IND_IMM) |-> ##2
            (instr_done_o && mem_req_o.wr && mem_req_o.wdata == $past(operand_i, 2));
    endproperty
    a_ind_imm: assert property (p_ind_imm) else $error("constant to indirect wrong");

    property p_no_write;
        (s_take(8'hFF, bmd_pkg::BMD_OP_A_DIR) or
         s_take(bmd_pkg::BMD_MASK_REG, bmd_pkg::BMD_OP_REG_IMM)) |-> ##1 !mem_req_o.wr [*4];
    endproperty
    a_no_write: assert property (p_no_write) else $error("stray memory write");

    property p_acc_kept;
        (s_take(bmd_pkg::BMD_MASK_IND, bmd_pkg::BMD_OP_IND_DIR) or
         s_take(bmd_pkg::BMD_MASK_REG, bmd_pkg::BMD_OP_REG_DIR)) |-> ##1 $stable(acc_o) [*4];
    endproperty
    a_acc_kept: assert property (p_acc_kept) else $error("acc changed by other move");

    property p_wr_pulse;
        mem_req_o.wr |=> !mem_req_o.wr;
    endproperty
    a_wr_pulse: assert property (p_wr_pulse) else $error("write strobe too long");

    property p_ill_done;
        instr_illegal_o |-> instr_done_o;
    endproperty
    a_ill_done: assert property (p_ill_done) else $error("illegal flag without done");

endmodule : bmd_move_chk

//--- bmd_dmem_model.sv
/*
 * Data memory model on the far side of the decoder memory port.
 * Assumes reads are answered in the rd cycle and held one cycle more.
 */
`timescale 1ns/1ps

module bmd_dmem_model (
    // Clock
    input  wire logic                  clk_i,
    // Request from the decoder
    input  wire bmd_pkg::bmd_mem_req_t mem_req_i,
    // Read data back to the decoder
    output      logic [7:0]            mem_rdata_o
);
    logic [7:0] mem [256];             // Byte storage, filled with inverted address
    logic [7:0] last_r;                // Last byte read
    logic       rd_q_r;                // Read strobe one cycle ago

    initial begin
        for (int a = 0; a < 256; a++) begin
            mem[a] = ~8'(a);
        end
        last_r = 8'h00;
        rd_q_r = 1'b0;
    end

    // Writes land on the strobe; read byte is held for one more cycle
    always @(posedge clk_i) begin
        rd_q_r <= mem_req_i.rd;
        if (mem_req_i.rd) begin
            last_r <= mem[mem_req_i.addr];
        end
        if (mem_req_i.wr) begin
            mem[mem_req_i.addr] <= mem_req_i.wdata;
        end
    end

    // Outside the hold time the bus shows garbage, not the stale byte
    assign mem_rdata_o = mem_req_i.rd ? mem[mem_req_i.addr] : (rd_q_r ? last_r : ~last_r);

endmodule : bmd_dmem_model

//--- testbench.sv
/*
 * Self-checking bench for the byte move decoder with a data memory model.
 * Assumes the decoder, its package, the checker and the model are compiled.
 */
`timescale 1ns/1ps

module testbench;
    logic                  clk_i;
    logic                  reset_i;
    logic                  instr_valid_i;
    logic [7:0]            opcode_i;
    logic [7:0]            operand_i;
    logic [1:0]            bank_sel_i;
    bmd_pkg::bmd_mem_req_t mem_req_o;
    logic [7:0]            mem_rdata_i;
    logic                  instr_done_o;
    logic                  instr_illegal_o;
    logic [1:0]            instr_len_o;
    logic [7:0]            acc_o;
    logic [7:0]            breg [4][8];   // Expected bank registers
    logic [7:0]            emem [256];    // Expected data memory
    logic [7:0]            eacc;          // Expected accumulator
    int                    miscompares;
    int                    n_compared;

    bmd_byte_move_decoder i_dut (
        .clk_i(clk_i), .reset_i(reset_i), .instr_valid_i(instr_valid_i),
        .opcode_i(opcode_i), .operand_i(operand_i), .bank_sel_i(bank_sel_i),
        .mem_req_o(mem_req_o), .mem_rdata_i(mem_rdata_i), .instr_done_o(instr_done_o),
        .instr_illegal_o(instr_illegal_o), .instr_len_o(instr_len_o), .acc_o(acc_o));

    bmd_dmem_model i_mem (.clk_i(clk_i), .mem_req_i(mem_req_o), .mem_rdata_o(mem_rdata_i));

    always #5 clk_i = ~clk_i;

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic results();
        $display("compared %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : results

    // One instruction: work out expectations, issue, wait for done, compare
    task automatic run(input logic [7:0] op, input logic [7:0] od, input logic [1:0] bk);
        int n;
        int nw;
        int lat;
        int ewr;
        logic [7:0] wa;
        logic [7:0] wd;
        logic [7:0] ea;
        logic [7:0] ed;
        logic [1:0] elen;
        logic       eill;
        lat = 2;
        ewr = 0;
        elen = bmd_pkg::BMD_LEN_TWO;
        eill = 1'b0;
        ea = 8'h00;
        ed = 8'h00;
        if (op == bmd_pkg::BMD_OP_A_DIR) eacc = emem[od];
        else if ((op & bmd_pkg::BMD_MASK_REG) == bmd_pkg::BMD_OP_REG_DIR) begin
            breg[bk][op[2:0]] = emem[od];
            lat = 3;
        end else if ((op & bmd_pkg::BMD_MASK_REG) == bmd_pkg::BMD_OP_REG_IMM) begin
            breg[bk][op[2:0]] = od;
        end else if ((op & bmd_pkg::BMD_MASK_IND) == bmd_pkg::BMD_OP_IND_DIR) begin
            ea = breg[bk][op[0]];
            ed = emem[od];
            ewr = 1;
            lat = 3;
        end else if ((op & bmd_pkg::BMD_MASK_IND) == bmd_pkg::BMD_OP_IND_IMM) begin
            ea = breg[bk][op[0]];
            ed = od;
            ewr = 1;
        end else if ((op & bmd_pkg::BMD_MASK_REG) == bmd_pkg::BMD_OP_A_REG) begin
            eacc = breg[bk][op[2:0]];
            elen = bmd_pkg::BMD_LEN_ONE;
        end else if ((op & bmd_pkg::BMD_MASK_IND) == bmd_pkg::BMD_OP_A_IND) begin
            eacc = emem[breg[bk][op[0]]];
            elen = bmd_pkg::BMD_LEN_ONE;
        end else if (op == bmd_pkg::BMD_OP_A_IMM) begin
            eacc = od;
        end else if ((op & bmd_pkg::BMD_MASK_REG) == bmd_pkg::BMD_OP_REG_A) begin
            breg[bk][op[2:0]] = eacc;
            elen = bmd_pkg::BMD_LEN_ONE;
        end else begin
            eill = 1'b1;
            lat = 1;
        end
        if (ewr != 0) emem[ea] = ed;
        @(posedge clk_i);
        instr_valid_i <= 1'b1;
        opcode_i      <= op;
        operand_i     <= od;
        bank_sel_i    <= bk;
        n = 0;
        nw = 0;
        do begin
            @(posedge clk_i);
            #1;
            n++;
            if (mem_req_o.wr === 1'b1) begin
                nw++;
                wa = mem_req_o.addr;
                wd = mem_req_o.wdata;
            end
        end while (instr_done_o !== 1'b1 && n < 12);
        check("latency", 8'(n), 8'(lat));
        check("illegal", {7'h00, instr_illegal_o}, {7'h00, eill});
        check("acc", acc_o, eacc);
        check("writes", 8'(nw), 8'(ewr));
        if (ewr != 0) check("waddr", wa, ea);
        if (ewr != 0) check("wdata", wd, ed);
        if (!eill) check("len", {6'h00, instr_len_o}, {6'h00, elen});
    endtask : run

    // Give every bank register a known random value
    task automatic init_regs();
        for (int b = 0; b < 4; b++) begin
            for (int r = 0; r < 8; r++) begin
                run(bmd_pkg::BMD_OP_REG_IMM | 8'(r), 8'($urandom), 2'(b));
            end
        end
    endtask : init_regs

    // Random mix of every form but indirect from accumulator, plus unknown opcodes
    task automatic rnd_op();
        logic [7:0] op;
        logic [2:0] r;
        r = 3'($urandom);
        case ($urandom % 10)
            0: op = bmd_pkg::BMD_OP_A_DIR;
            1: op = bmd_pkg::BMD_OP_REG_DIR | {5'h00, r};
            2: op = bmd_pkg::BMD_OP_REG_IMM | {5'h00, r};
            3: op = bmd_pkg::BMD_OP_IND_DIR | {7'h00, r[0]};
            4: op = bmd_pkg::BMD_OP_IND_IMM | {7'h00, r[0]};
            5: op = bmd_pkg::BMD_OP_A_REG | {5'h00, r};
            6: op = bmd_pkg::BMD_OP_A_IND | {7'h00, r[0]};
            7: op = bmd_pkg::BMD_OP_A_IMM;
            8: op = bmd_pkg::BMD_OP_REG_A | {5'h00, r};
            default: op = r[0] ? 8'h00 : 8'h24;
        endcase
        run(op, 8'($urandom), 2'($urandom));
    endtask : rnd_op

    initial begin
        #200000;
        miscompares++;
        results();
    end

    initial begin
        clk_i = 1'b0;
        reset_i = 1'b1;
        instr_valid_i = 1'b0;
        opcode_i = 8'h00;
        operand_i = 8'h00;
        bank_sel_i = 2'h0;
        eacc = bmd_pkg::BMD_ACC_RST;
        for (int a = 0; a < 256; a++) emem[a] = ~8'(a);
        void'($urandom(72));
        repeat (3) @(posedge clk_i);
        reset_i <= 1'b0;
        for (int pass = 0; pass < 2; pass++) begin
            #1;
            check("acc_rst", acc_o, bmd_pkg::BMD_ACC_RST);
            init_regs();
            run(bmd_pkg::BMD_OP_A_REG | 8'h07, 8'h00, 2'h3);
            run(bmd_pkg::BMD_OP_IND_IMM | 8'h01, 8'hFF, 2'h3);
            run(bmd_pkg::BMD_OP_IND_DIR, 8'h00, 2'h0);
            run(8'h00, 8'hFF, 2'h1);
            repeat (100) rnd_op();
            @(posedge clk_i);
            instr_valid_i <= 1'b0;
            reset_i <= 1'b1;
            @(posedge clk_i);
            reset_i <= 1'b0;
            eacc = bmd_pkg::BMD_ACC_RST;
        end
        results();
    end
endmodule : testbench

bind bmd_byte_move_decoder bmd_move_chk i_chk (
    .clk_i(clk_i), .reset_i(reset_i), .instr_valid_i(instr_valid_i),
    .opcode_i(opcode_i), .operand_i(operand_i), .bank_sel_i(bank_sel_i),
    .mem_req_o(mem_req_o), .mem_rdata_i(mem_rdata_i), .instr_done_o(instr_done_o),
    .instr_illegal_o(instr_illegal_o), .instr_len_o(instr_len_o), .acc_o(acc_o));
